// [brf_pkg.sv]
/*
 * Package for the banked core register file: widths, mode encodings,
 * physical register indices and status word field positions.
 * Assumes nothing of its surroundings.
 */
package brf_pkg;

    localparam int DATA_W      = 32;
    localparam int IDX_W       = 4;
    localparam int PHYS_GP_N   = 31;
    localparam int PHYS_W      = 5;
    localparam int SAVED_N     = 5;
    localparam int MODE_W      = 5;

    // Mode field codes of the status word
    typedef enum logic [4:0] {
        BRF_MODE_USER      = 5'h10,
        BRF_MODE_FAST      = 5'h11,
        BRF_MODE_NORMAL    = 5'h12,
        BRF_MODE_SUPER     = 5'h13,
        BRF_MODE_ABORT     = 5'h17,
        BRF_MODE_UNDEFINED = 5'h1B,
        BRF_MODE_SYSTEM    = 5'h1F
    } brf_mode_t;

    // Status word field positions
    localparam int SW_MODE_LSB = 0;
    localparam int SW_STATE_BIT = 5;
    localparam int SW_FAST_DIS_BIT = 6;
    localparam int SW_IRQ_DIS_BIT = 7;
    localparam logic [31:0] SW_RESET = 32'h000000D3;

    // Architectural indices of special registers
    localparam logic [3:0] IDX_FAST_LO = 4'h8;
    localparam logic [3:0] IDX_FAST_HI = 4'hC;
    localparam logic [3:0] IDX_SP      = 4'hD;
    localparam logic [3:0] IDX_LINK    = 4'hE;
    localparam logic [3:0] IDX_PC      = 4'hF;

    // Physical layout: 0..15 user set (15 = program counter)
    localparam logic [4:0] PHYS_FAST_BASE    = 5'h10;
    localparam logic [4:0] PHYS_FAST_SP      = 5'h15;
    localparam logic [4:0] PHYS_NORMAL_SP    = 5'h17;
    localparam logic [4:0] PHYS_SUPER_SP     = 5'h19;
    localparam logic [4:0] PHYS_ABORT_SP     = 5'h1B;
    localparam logic [4:0] PHYS_UNDEFINED_SP = 5'h1D;

    // Saved status word slots
    localparam logic [2:0] SAVED_FAST      = 3'h0;
    localparam logic [2:0] SAVED_NORMAL    = 3'h1;
    localparam logic [2:0] SAVED_SUPER     = 3'h2;
    localparam logic [2:0] SAVED_ABORT     = 3'h3;
    localparam logic [2:0] SAVED_UNDEFINED = 3'h4;
    localparam logic [2:0] SAVED_NONE      = 3'h7;

    // Instruction widths per execution state
    localparam int INSTR_W_FULL    = 32;
    localparam int INSTR_W_COMPACT = 16;

    // Pipeline stage codes
    typedef enum logic [1:0] {
        BRF_STG_FETCH   = 2'b00,
        BRF_STG_DECODE  = 2'b01,
        BRF_STG_EXECUTE = 2'b10
    } brf_stage_t;

    // Access sizes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

endpackage

// [brf_map.sv]
/*
 * Index translator: maps an architectural register index and mode to
 * a physical register select, combinationally.
 * Assumes the mode input is one of the seven legal mode codes.
 */
`timescale 1ns/100ps
`default_nettype none

module brf_map (
    input  wire logic [3:0] idx_in,
    input  wire logic [4:0] mode_in,
    output logic      [4:0] phys_out
);

    logic [4:0] sp_base;

    // ------------------------------------------------------------
    // Banked stack pointer base per mode
    // ------------------------------------------------------------
    always_comb begin
        case (mode_in)
            brf_pkg::BRF_MODE_FAST:      sp_base = brf_pkg::PHYS_FAST_SP;
            brf_pkg::BRF_MODE_NORMAL:    sp_base = brf_pkg::PHYS_NORMAL_SP;
            brf_pkg::BRF_MODE_SUPER:     sp_base = brf_pkg::PHYS_SUPER_SP;
            brf_pkg::BRF_MODE_ABORT:     sp_base = brf_pkg::PHYS_ABORT_SP;
            brf_pkg::BRF_MODE_UNDEFINED: sp_base = brf_pkg::PHYS_UNDEFINED_SP;
            default:                     sp_base = {1'b0, brf_pkg::IDX_SP};
        endcase
    end

    // ------------------------------------------------------------
    // Index translation
    // ------------------------------------------------------------
    always_comb begin
        phys_out = {1'b0, idx_in};
        if (idx_in >= brf_pkg::IDX_FAST_LO && idx_in <= brf_pkg::IDX_FAST_HI) begin
            if (mode_in == brf_pkg::BRF_MODE_FAST) begin
                phys_out = brf_pkg::PHYS_FAST_BASE + 5'(idx_in - brf_pkg::IDX_FAST_LO);
            end
        end else if (idx_in == brf_pkg::IDX_SP || idx_in == brf_pkg::IDX_LINK) begin
            phys_out = sp_base + 5'(idx_in - brf_pkg::IDX_SP);
        end
    end

endmodule

`default_nettype wire

// [brf_core_regs.sv]
/*
 * Banked register file of the core: 31 general registers and 6 status
 * words, two read ports, decode and execute write ports, program counter
 * port, mode change and exception entry.
 * Assumes the decode and execute logic of the core on the same clock.
 */
// Overview of operation
// - Holds 31 general 32-bit registers and 6 status words.
// - Sixteen registers visible; physical choice follows current mode.
// - Index fifteen is the program counter in every mode.
// - A call writes its return address into index fourteen of current mode.
// - Indices zero to seven are one shared physical set.
// - Indices eight to fourteen are banked by mode.
// - Fast interrupt mode has private registers for indices eight to twelve.
// - Each exception mode has private indices thirteen and fourteen.
// - System mode uses the user registers, no banks.
// - One shared current status word; five saved words filled on entry.
// - Seven modes, all distinguished.
// - Instructions 32 bits in full state, 16 bits in compact state.
// - Byte, halfword, word accesses; words and halfwords naturally aligned.
// - Fetch, decode, execute in order.
// - Mode changes by software write, exception entry or exception return.
`timescale 1ns/100ps
`default_nettype none

module brf_core_regs #(
    parameter int DATA_W = brf_pkg::DATA_W
) (
    input  wire logic              ref_clk_in,
    input  wire logic              nrst_in,
    input  wire logic [3:0]        rd_a_idx_in,
    input  wire logic [3:0]        rd_b_idx_in,
    input  wire logic              dec_wr_en_in,
    input  wire logic [3:0]        dec_wr_idx_in,
    input  wire logic [DATA_W-1:0] dec_wr_data_in,
    input  wire logic              exe_wr_en_in,
    input  wire logic [3:0]        exe_wr_idx_in,
    input  wire logic [DATA_W-1:0] exe_wr_data_in,
    input  wire logic              call_en_in,
    input  wire logic [DATA_W-1:0] call_return_in,
    input  wire logic              pc_adv_in,
    input  wire logic              sw_wr_en_in,
    input  wire logic [DATA_W-1:0] sw_wr_data_in,
    input  wire logic              saved_wr_en_in,
    input  wire logic [DATA_W-1:0] saved_wr_data_in,
    input  wire logic              exc_take_in,
    input  wire logic [4:0]        exc_mode_in,
    input  wire logic [DATA_W-1:0] exc_vector_in,
    input  wire logic [DATA_W-1:0] exc_return_in,
    input  wire logic              exc_return_in_en_in,
    input  wire logic [DATA_W-1:0] acc_addr_in,
    input  wire logic [1:0]        acc_size_in,
    input  wire logic              acc_en_in,
    output logic      [DATA_W-1:0] rd_a_data_out,
    output logic      [DATA_W-1:0] rd_b_data_out,
    output logic      [DATA_W-1:0] pc_out,
    output logic      [DATA_W-1:0] current_status_word_out,
    output logic      [DATA_W-1:0] saved_status_word_out,
    output logic      [4:0]        mode_out,
    output logic                   compact_state_out,
    output logic                   misalign_out,
    output logic      [1:0]        stage_out
);

    if (DATA_W != 32) begin : g_width_check
        $error("brf_core_regs supports DATA_W of 32 only");
    end

    logic [DATA_W-1:0] gp_reg [brf_pkg::PHYS_GP_N];
    logic [DATA_W-1:0] saved_reg [brf_pkg::SAVED_N];
    logic [DATA_W-1:0] status_reg;
    logic [4:0]        mode_w;
    logic [4:0]        rd_a_phys;
    logic [4:0]        rd_b_phys;
    logic [4:0]        dec_phys;
    logic [4:0]        exe_phys;
    logic [4:0]        link_phys;
    logic [4:0]        exc_link_phys;
    logic [2:0]        saved_sel;
    logic [2:0]        exc_saved_sel;
    logic [1:0]        stage_reg;
    logic [DATA_W-1:0] pc_step;
    logic [DATA_W-1:0] exc_status;

    assign mode_w  = status_reg[brf_pkg::SW_MODE_LSB +: brf_pkg::MODE_W];
    assign pc_step = status_reg[brf_pkg::SW_STATE_BIT]
                   ? DATA_W'(brf_pkg::INSTR_W_COMPACT / 8)
                   : DATA_W'(brf_pkg::INSTR_W_FULL / 8);

    // ------------------------------------------------------------
    // Index translation per port
    // ------------------------------------------------------------
    brf_map u_map_a (.idx_in(rd_a_idx_in), .mode_in(mode_w), .phys_out(rd_a_phys));
    brf_map u_map_b (.idx_in(rd_b_idx_in), .mode_in(mode_w), .phys_out(rd_b_phys));
    brf_map u_map_d (.idx_in(dec_wr_idx_in), .mode_in(mode_w), .phys_out(dec_phys));
    brf_map u_map_e (.idx_in(exe_wr_idx_in), .mode_in(mode_w), .phys_out(exe_phys));
    brf_map u_map_l (.idx_in(brf_pkg::IDX_LINK), .mode_in(mode_w), .phys_out(link_phys));
    brf_map u_map_x (.idx_in(brf_pkg::IDX_LINK), .mode_in(exc_mode_in),
                     .phys_out(exc_link_phys));

    function automatic logic [2:0] saved_of(input logic [4:0] m);
        case (m)
            brf_pkg::BRF_MODE_FAST:      saved_of = brf_pkg::SAVED_FAST;
            brf_pkg::BRF_MODE_NORMAL:    saved_of = brf_pkg::SAVED_NORMAL;
            brf_pkg::BRF_MODE_SUPER:     saved_of = brf_pkg::SAVED_SUPER;
            brf_pkg::BRF_MODE_ABORT:     saved_of = brf_pkg::SAVED_ABORT;
            brf_pkg::BRF_MODE_UNDEFINED: saved_of = brf_pkg::SAVED_UNDEFINED;
            default:                     saved_of = brf_pkg::SAVED_NONE;
        endcase
    endfunction

    assign saved_sel     = saved_of(mode_w);
    assign exc_saved_sel = saved_of(exc_mode_in);

    // ------------------------------------------------------------
    // Status word taken on exception entry
    // ------------------------------------------------------------
    always_comb begin
        exc_status = status_reg;
        exc_status[brf_pkg::SW_MODE_LSB +: brf_pkg::MODE_W] = exc_mode_in;
        exc_status[brf_pkg::SW_STATE_BIT]    = 1'b0;
        exc_status[brf_pkg::SW_FAST_DIS_BIT] = 1'b1;
        exc_status[brf_pkg::SW_IRQ_DIS_BIT]  = 1'b1;
    end

    // ------------------------------------------------------------
    // General registers, program counter at index fifteen
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < brf_pkg::PHYS_GP_N; i++) begin
                gp_reg[i] <= '0;
            end
        end else begin
            if (pc_adv_in) begin
                gp_reg[brf_pkg::IDX_PC] <= gp_reg[brf_pkg::IDX_PC] + pc_step;
            end
            if (dec_wr_en_in) begin
                gp_reg[dec_phys] <= dec_wr_data_in;
            end
            if (call_en_in) begin
                gp_reg[link_phys] <= call_return_in;
            end
            if (exe_wr_en_in) begin
                gp_reg[exe_phys] <= exe_wr_data_in;
            end
            if (exc_take_in) begin
                gp_reg[exc_link_phys]    <= exc_return_in;
                gp_reg[brf_pkg::IDX_PC]  <= exc_vector_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Current and saved status words
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            status_reg <= brf_pkg::SW_RESET;
        end else if (exc_take_in) begin
            status_reg <= exc_status;
        end else if (exc_return_in_en_in && saved_sel != brf_pkg::SAVED_NONE) begin
            status_reg <= saved_reg[saved_sel];
        end else if (sw_wr_en_in) begin
            status_reg <= sw_wr_data_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < brf_pkg::SAVED_N; i++) begin
                saved_reg[i] <= '0;
            end
        end else if (exc_take_in && exc_saved_sel != brf_pkg::SAVED_NONE) begin
            saved_reg[exc_saved_sel] <= status_reg;
        end else if (saved_wr_en_in && saved_sel != brf_pkg::SAVED_NONE) begin
            saved_reg[saved_sel] <= saved_wr_data_in;
        end
    end

    // ------------------------------------------------------------
    // Pipeline stage tracker
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stage_reg <= brf_pkg::BRF_STG_FETCH;
        end else begin
            case (stage_reg)
                brf_pkg::BRF_STG_FETCH:  stage_reg <= brf_pkg::BRF_STG_DECODE;
                brf_pkg::BRF_STG_DECODE: stage_reg <= brf_pkg::BRF_STG_EXECUTE;
                default:                 stage_reg <= brf_pkg::BRF_STG_FETCH;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_a_data_out           <= '0;
            rd_b_data_out           <= '0;
            pc_out                  <= '0;
            current_status_word_out <= brf_pkg::SW_RESET;
            saved_status_word_out   <= '0;
            mode_out                <= brf_pkg::SW_RESET[4:0];
            compact_state_out       <= 1'b0;
            misalign_out            <= 1'b0;
            stage_out               <= brf_pkg::BRF_STG_FETCH;
        end else begin
            rd_a_data_out           <= gp_reg[rd_a_phys];
            rd_b_data_out           <= gp_reg[rd_b_phys];
            pc_out                  <= gp_reg[brf_pkg::IDX_PC];
            current_status_word_out <= status_reg;
            saved_status_word_out   <= (saved_sel == brf_pkg::SAVED_NONE)
                                     ? '0 : saved_reg[saved_sel];
            mode_out                <= mode_w;
            compact_state_out       <= status_reg[brf_pkg::SW_STATE_BIT];
            misalign_out            <= acc_en_in &&
                ((acc_size_in == brf_pkg::SIZE_WORD && acc_addr_in[1:0] != 2'h0) ||
                 (acc_size_in == brf_pkg::SIZE_HALF && acc_addr_in[0]));
            stage_out               <= stage_reg;
        end
    end

endmodule

`default_nettype wire

// [brf_core_regs_sva.sv]
/* Port checker for the banked core register file.
   Assumes it is bound to every brf_core_regs instance. */
`timescale 1ns/100ps
`default_nettype none
module brf_core_regs_sva (
    input wire logic        ref_clk_in,
    input wire logic        nrst_in,
    input wire logic        exe_wr_en_in,
    input wire logic [3:0]  exe_wr_idx_in,
    input wire logic [31:0] exe_wr_data_in,
    input wire logic        dec_wr_en_in,
    input wire logic        sw_wr_en_in,
    input wire logic [31:0] sw_wr_data_in,
    input wire logic        exc_take_in,
    input wire logic [4:0]  exc_mode_in,
    input wire logic        exc_return_in_en_in,
    input wire logic [3:0]  rd_a_idx_in,
    input wire logic [31:0] rd_a_data_out,
    input wire logic [31:0] acc_addr_in,
    input wire logic [1:0]  acc_size_in,
    input wire logic        acc_en_in,
    input wire logic        misalign_out,
    input wire logic [1:0]  stage_out,
    input wire logic [4:0]  mode_out,
    input wire logic        compact_state_out,
    input wire logic [31:0] saved_status_word_out,
    input wire logic [31:0] current_status_word_out,
    input wire logic [31:0] pc_out
);
    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    logic bad;
    assign bad = (acc_size_in == 2'h2 && acc_addr_in[1:0] != 2'h0)
              || (acc_size_in == 2'h1 && acc_addr_in[0]);
    sequence quiet_s;
        !sw_wr_en_in && !exc_take_in && !exc_return_in_en_in;
    endsequence
    sequence mode_wr_s;
        sw_wr_en_in && !exc_take_in && !exc_return_in_en_in ##1 quiet_s;
    endsequence
    sequence exc_s;
        exc_take_in ##1 quiet_s;
    endsequence
    sequence low_wr_s;
        exe_wr_en_in && exe_wr_idx_in < 4'h8 ##1
        !exe_wr_en_in && !dec_wr_en_in && rd_a_idx_in == $past(exe_wr_idx_in);
    endsequence
    chk_misalign_flag: assert property (acc_en_in |=> misalign_out == $past(bad))
        else $error("misalign flag wrong");
    chk_misalign_quiet: assert property (!acc_en_in |=> !misalign_out)
        else $error("misalign flag without access");
    chk_stage_order: assert property (nrst_in && $past(nrst_in) |=> stage_out ==
        (($past(stage_out) == 2'h2) ? 2'h0 : $past(stage_out) + 2'h1))
        else $error("stage order wrong");
    chk_mode_write: assert property (mode_wr_s |=> mode_out == $past(sw_wr_data_in[4:0], 2))
        else $error("mode write not applied");
    chk_exc_mode: assert property (exc_s |=> mode_out == $past(exc_mode_in, 2))
        else $error("exception mode wrong");
    chk_exc_state: assert property (exc_s |=> !compact_state_out)
        else $error("exception kept compact state");
    chk_low_shared: assert property (low_wr_s |=> rd_a_data_out == $past(exe_wr_data_in, 2))
        else $error("shared register readback wrong");
    chk_reset_state: assert property (disable iff (1'b0) !nrst_in && $past(!nrst_in) |->
        mode_out == 5'h13
        && current_status_word_out == 32'h000000D3 && pc_out == 32'h0)
        else $error("reset state wrong");
    chk_saved_user: assert property ((mode_out == 5'h10)[*3] |-> saved_status_word_out == 32'h0)
        else $error("saved word seen in user mode");
endmodule
bind brf_core_regs brf_core_regs_sva i_sva (.ref_clk_in, .nrst_in, .exe_wr_en_in,
    .exe_wr_idx_in, .exe_wr_data_in, .dec_wr_en_in, .sw_wr_en_in, .sw_wr_data_in,
    .exc_take_in, .exc_mode_in, .exc_return_in_en_in, .rd_a_idx_in, .rd_a_data_out,
    .acc_addr_in, .acc_size_in, .acc_en_in, .misalign_out, .stage_out, .mode_out,
    .compact_state_out, .saved_status_word_out, .current_status_word_out, .pc_out);
`default_nettype wire

// [brf_pipe_model.sv]
/* Execute stage access generator sweeping sizes and address offsets.
   Assumes the core clock and reset of the register file. */
`timescale 1ns/100ps
`default_nettype none
module brf_pipe_model (
    input  wire logic        ref_clk_in,
    input  wire logic        nrst_in,
    input  wire logic        run_in,
    input  wire logic        aligned_in,
    output logic      [31:0] acc_addr_out,
    output logic      [1:0]  acc_size_out,
    output logic             acc_en_out
);
    // ------------------------------------------------------------
    // Access sweep
    // ------------------------------------------------------------
    logic [7:0] step_reg;
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            step_reg <= 8'h00;
        end else if (run_in) begin
            step_reg <= step_reg + 8'h01;
        end
    end
    always_comb begin
        acc_en_out = run_in;
        acc_size_out = (step_reg[1:0] == 2'h3) ? 2'h2 : step_reg[1:0];
        acc_addr_out = {22'h0, step_reg, step_reg[3:2]};
        if (aligned_in && acc_size_out == 2'h2) begin
            acc_addr_out[1:0] = 2'h0;
        end
        if (aligned_in && acc_size_out == 2'h1) begin
            acc_addr_out[0] = 1'b0;
        end
        if (!run_in) begin
            acc_addr_out = ~acc_addr_out;
        end
    end
endmodule
`default_nettype wire

// [brf_core_regs_tb.sv]
/* Self-checking bench for the banked core register file.
   Assumes the checker is bound and the access model drives the access ports. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: %s", $time, m); end end
module brf_core_regs_tb;
    // ------------------------------------------------------------
    // Stimulus and checks
    // ------------------------------------------------------------
    typedef struct packed {logic [4:0] ma; logic [4:0] mb; logic [3:0] idx; logic bank;} brf_row_t;
    brf_row_t rows [8] = '{'{5'h10, 5'h11, 4'h3, 1'b0}, '{5'h10, 5'h11, 4'h8, 1'b1},
        '{5'h10, 5'h11, 4'hC, 1'b1}, '{5'h10, 5'h13, 4'hC, 1'b0}, '{5'h13, 5'h17, 4'hD, 1'b1},
        '{5'h12, 5'h1B, 4'hE, 1'b1}, '{5'h10, 5'h1F, 4'hD, 1'b0}, '{5'h11, 5'h12, 4'hD, 1'b1}};
    logic [4:0] modes [7] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h1F};
    logic ref_clk_in, nrst_in, dec_wr_en_in, exe_wr_en_in, call_en_in, pc_adv_in, sw_wr_en_in;
    logic exc_take_in, exc_return_in_en_in, run, aligned, compact_state_out, misalign_out;
    logic [3:0] rd_a_idx_in, rd_b_idx_in, dec_wr_idx_in, exe_wr_idx_in;
    logic [31:0] dec_wr_data_in, exe_wr_data_in, call_return_in, sw_wr_data_in, exc_vector_in;
    logic [31:0] exc_return_in, acc_addr_in, rd_a_data_out, rd_b_data_out, pc_out;
    logic [31:0] current_status_word_out, saved_status_word_out;
    logic [4:0] exc_mode_in, mode_out;
    logic [1:0] acc_size_in, stage_out;
    logic acc_en_in;
    int err_total = 0;
    int comparisons = 0;
    int mis_cnt = 0;
    brf_core_regs i_dut (.ref_clk_in, .nrst_in, .rd_a_idx_in, .rd_b_idx_in, .dec_wr_en_in,
        .dec_wr_idx_in, .dec_wr_data_in, .exe_wr_en_in, .exe_wr_idx_in, .exe_wr_data_in,
        .call_en_in, .call_return_in, .pc_adv_in, .sw_wr_en_in, .sw_wr_data_in,
        .saved_wr_en_in(1'b0), .saved_wr_data_in(32'h0), .exc_take_in, .exc_mode_in,
        .exc_vector_in, .exc_return_in, .exc_return_in_en_in, .acc_addr_in, .acc_size_in,
        .acc_en_in, .rd_a_data_out, .rd_b_data_out, .pc_out, .current_status_word_out,
        .saved_status_word_out, .mode_out, .compact_state_out, .misalign_out, .stage_out);
    brf_pipe_model i_model (.ref_clk_in, .nrst_in, .run_in(run), .aligned_in(aligned),
        .acc_addr_out(acc_addr_in), .acc_size_out(acc_size_in), .acc_en_out(acc_en_in));
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic set_sw(input logic [31:0] d);
        @(posedge ref_clk_in); sw_wr_en_in <= 1'b1; sw_wr_data_in <= d;
        @(posedge ref_clk_in); sw_wr_en_in <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        @(posedge ref_clk_in); exe_wr_en_in <= 1'b1; exe_wr_idx_in <= i; exe_wr_data_in <= d;
        @(posedge ref_clk_in); exe_wr_en_in <= 1'b0;
    endtask
    task automatic chk_rd(input logic [3:0] i, input logic [31:0] e);
        @(posedge ref_clk_in); rd_a_idx_in <= i; rd_b_idx_in <= i;
        @(posedge ref_clk_in); #1;
        `CHK(rd_a_data_out, e, "read port a")
        `CHK(rd_b_data_out, e, "read port b")
    endtask
    task automatic settle();
        repeat (2) @(posedge ref_clk_in);
        #1;
    endtask
    initial begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) if (misalign_out === 1'b1) mis_cnt++;
    initial begin
        repeat (5000) @(posedge ref_clk_in);
        err_total++;
        tally_and_finish();
    end
    initial begin
        {nrst_in, dec_wr_en_in, exe_wr_en_in, call_en_in, pc_adv_in, sw_wr_en_in} = '0;
        {exc_take_in, exc_return_in_en_in, run, aligned, rd_a_idx_in, rd_b_idx_in} = '0;
        {dec_wr_idx_in, exe_wr_idx_in, dec_wr_data_in, exe_wr_data_in, call_return_in} = '0;
        {sw_wr_data_in, exc_vector_in, exc_return_in, exc_mode_in} = '0;
        repeat (5) @(posedge ref_clk_in);
        #1;
        `CHK(mode_out, 5'h13, "reset mode")
        `CHK(current_status_word_out, 32'h000000D3, "reset status")
        `CHK(pc_out, 32'h0, "reset pc")
        @(posedge ref_clk_in); nrst_in <= 1'b1;
        foreach (rows[k]) begin
            set_sw({24'h0, 3'h6, rows[k].ma});
            wr(rows[k].idx, 32'hA0000000 | k);
            set_sw({24'h0, 3'h6, rows[k].mb});
            wr(rows[k].idx, 32'hB0000000 | k);
            set_sw({24'h0, 3'h6, rows[k].ma});
            chk_rd(rows[k].idx, (rows[k].bank ? 32'hA0000000 : 32'hB0000000) | k);
        end
        foreach (modes[k]) begin
            set_sw({24'h0, 3'h6, modes[k]});
            settle();
            `CHK(mode_out, modes[k], "mode select")
        end
        @(posedge ref_clk_in); {dec_wr_en_in, exe_wr_en_in} <= 2'h3;
        {dec_wr_idx_in, exe_wr_idx_in, dec_wr_data_in, exe_wr_data_in} <= {8'h22, 32'hD, 32'hE};
        @(posedge ref_clk_in); {dec_wr_en_in, exe_wr_en_in} <= 2'h0;
        rd_a_idx_in <= 4'h2;
        chk_rd(4'h2, 32'hE);
        set_sw(32'h000000D2);
        @(posedge ref_clk_in); call_en_in <= 1'b1; call_return_in <= 32'h00000C40;
        @(posedge ref_clk_in); call_en_in <= 1'b0;
        chk_rd(4'hE, 32'h00000C40);
        set_sw(32'h000000F0);
        chk_rd(4'hE, 32'h0);
        @(posedge ref_clk_in); exc_take_in <= 1'b1; exc_mode_in <= 5'h11;
        exc_vector_in <= 32'h00000100; exc_return_in <= 32'h00000240;
        @(posedge ref_clk_in); exc_take_in <= 1'b0;
        settle();
        `CHK(mode_out, 5'h11, "exception mode")
        `CHK(saved_status_word_out, 32'h000000F0, "saved word")
        `CHK(pc_out, 32'h00000100, "vector")
        chk_rd(4'hE, 32'h00000240);
        @(posedge ref_clk_in); exc_return_in_en_in <= 1'b1;
        @(posedge ref_clk_in); exc_return_in_en_in <= 1'b0;
        settle();
        `CHK(mode_out, 5'h10, "return mode")
        `CHK(compact_state_out, 1'b1, "compact state restored")
        @(posedge ref_clk_in); pc_adv_in <= 1'b1;
        @(posedge ref_clk_in); pc_adv_in <= 1'b0;
        set_sw(32'h000000D0);
        @(posedge ref_clk_in); pc_adv_in <= 1'b1;
        @(posedge ref_clk_in); pc_adv_in <= 1'b0;
        settle();
        `CHK(pc_out, 32'h00000106, "pc step")
        chk_rd(4'hF, 32'h00000106);
        @(posedge ref_clk_in); run <= 1'b1; aligned <= 1'b1;
        repeat (40) @(posedge ref_clk_in);
        aligned <= 1'b0;
        @(posedge ref_clk_in); #1;
        `CHK(mis_cnt == 0, 1'b1, "aligned access flagged")
        repeat (40) @(posedge ref_clk_in);
        run <= 1'b0;
        settle();
        `CHK(mis_cnt > 0, 1'b1, "misaligned access missed")
        tally_and_finish();
    end
endmodule
`default_nettype wire
